/* hw/card_irq_defines.svh */
// Register offsets, field positions and reset values of the card interrupt block
`ifndef CARD_IRQ_DEFINES_SVH
`define CARD_IRQ_DEFINES_SVH
// ----------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------
`define CIRQ_IDX_W 16
`define CIRQ_IDX_FLAGS 16'hFE01
`define CIRQ_IDX_ENABLE 16'hFE02
`define CIRQ_IDX_CONFIG 16'hFE08
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIRQ_FLAGS_RST 8'h00
`define CIRQ_ENABLE_RST 8'h00
`define CIRQ_CONFIG_RST 6'h00
// ----------------------------------------
// Flag and enable bit positions
// ----------------------------------------
`define CIRQ_B_WAIT 7
`define CIRQ_B_CARD 6
`define CIRQ_B_SUPPLY 5
`define CIRQ_B_RXAV 4
`define CIRQ_B_TXEV 3
`define CIRQ_B_TX_SENT_FLAG 2
`define CIRQ_B_TX_ERROR_FLAG 1
`define CIRQ_B_RX_ERROR_FLAG 0
// Flags cleared by a read of the flag register
`define CIRQ_COR_MASK 8'hE4
// Flags cleared by a read of the transmit control register
`define CIRQ_TXRD_MASK 8'h0A
// Flags cleared by a read of the receive control register
`define CIRQ_RXRD_MASK 8'h01
// ----------------------------------------
// Interface select field codes
// ----------------------------------------
`define CIRQ_SEL_NONE 2'h0
`define CIRQ_SEL_EXT 2'h1
`endif

/* hw/card_irq_pkg.sv */
// Types shared by the card interrupt block
package card_irq_pkg;
   // Event and status lines from one card interface, same clock domain
   typedef struct packed {
      logic timeout;        // Answer or wait timeout pulse
      logic length_done;    // Receive length terminal count pulse
      logic supply_timeout; // Supply stable timer expiry pulse
      logic fault;          // Interface fault pulse
      logic rx_nonempty;    // Receive FIFO holds data, level
      logic tx_empty;       // Transmit FIFO empty, level
      logic tx_full;        // Transmit FIFO full, level
      logic tx_sent;        // Byte sent pulse
      logic tx_break;       // Break recorded pulse
      logic tx_underrun;    // Underrun recorded pulse
      logic rx_overrun;     // Receive overrun pulse
      logic rx_parity;      // Receive parity error pulse
   } evt_s;

   // Software configuration register layout
   typedef struct packed {
      logic break_detect_en; // Bit 5
      logic t0_protocol;     // Bit 4
      logic [1:0] interface_select_field; // Bits 3:2
      logic bypass;          // Bit 1
      logic sync_mode;       // Bit 0
   } cfg_s;
endpackage

/* hw/pin_edge_sync.sv */
// Two-flop synchroniser with edge detection for one asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;
   // Fills with ones after reset; edges wait until the delay stage holds a real sample
   logic [2:0] fill_reg;

   // ----------------------------------------
   // Synchroniser and delay stage
   // ----------------------------------------
   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
         fill_reg <= 3'h0;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         fill_reg <= {fill_reg[1:0], 1'b1};
      end
   end

   // Edges from synchronised copies only; a pin resting high gives no false edge after reset
   assign level_o = sync_reg;
   assign rise_o = fill_reg[2] & sync_reg & ~last_reg;
   assign fall_o = fill_reg[2] & ~sync_reg & last_reg;
endmodule // pin_edge_sync
`default_nettype wire

/* hw/smart_card_interrupt_flags.sv */
// Card interrupt flag and enable registers with Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "card_irq_defines.svh"
module smart_card_interrupt_flags #(
   parameter int ADR_W = 18,
   parameter int DATA_W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [DATA_W-1:0] dat_i,
   input wire logic [DATA_W/8-1:0] sel_i,
   output logic [DATA_W-1:0] dat_o,
   output logic ack_o,
   // Event sources of both interfaces
   input wire card_irq_pkg::evt_s ext_evt_i,
   input wire card_irq_pkg::evt_s int_evt_i,
   // Asynchronous pins
   input wire logic card_detect_ext_i,
   input wire logic card_detect_int_i,
   input wire logic io_ext_i,
   input wire logic io_int_i,
   // Power-down level and control register read strobes
   input wire logic power_down_i,
   input wire logic tx_ctl_read_i,
   input wire logic rx_ctl_read_i,
   // Interrupt toward the processor
   output logic irq_o
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (DATA_W < 8 || DATA_W % 8 != 0) begin : g_bad_data
      $error("DATA_W must be a multiple of 8, at least 8");
   end
   if (ADR_W < `CIRQ_IDX_W + 2) begin : g_bad_adr
      $error("ADR_W too small for the register indices");
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [7:0] enable_reg;
   card_irq_pkg::cfg_s cfg_reg;
   logic ack_reg;
   logic [DATA_W-1:0] dat_reg;
   logic tx_empty_reg;
   logic tx_full_reg;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic det_ext_rise, det_ext_fall, det_int_rise, det_int_fall;
   logic io_ext_fall, io_int_fall;

   pin_edge_sync u_det_ext (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(card_detect_ext_i),
      .level_o(),
      .rise_o(det_ext_rise),
      .fall_o(det_ext_fall)
   );
   pin_edge_sync u_det_int (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(card_detect_int_i),
      .level_o(),
      .rise_o(det_int_rise),
      .fall_o(det_int_fall)
   );
   pin_edge_sync u_io_ext (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(io_ext_i),
      .level_o(),
      .rise_o(),
      .fall_o(io_ext_fall)
   );
   pin_edge_sync u_io_int (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(io_int_i),
      .level_o(),
      .rise_o(),
      .fall_o(io_int_fall)
   );

   // ----------------------------------------
   // Interface selection
   // ----------------------------------------
   // Unselected interface contributes nothing
   wire [1:0] sel_field = cfg_reg.interface_select_field;
   wire sel_ext = (sel_field == `CIRQ_SEL_EXT);
   wire sel_int = sel_field[1];
   card_irq_pkg::evt_s evt;
   assign evt = sel_ext ? ext_evt_i : (sel_int ? int_evt_i : '0);
   wire det_edge = sel_ext ? (det_ext_rise | det_ext_fall)
                 : (sel_int & (det_int_rise | det_int_fall));
   wire io_fall = sel_ext ? io_ext_fall : (sel_int & io_int_fall);

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire [ADR_W-3:0] word_idx = adr_i[ADR_W-1:2];
   wire hit = cyc_i & stb_i & ~ack_reg;
   wire is_flags = (word_idx == (ADR_W-2)'(`CIRQ_IDX_FLAGS));
   wire is_enable = (word_idx == (ADR_W-2)'(`CIRQ_IDX_ENABLE));
   wire is_config = (word_idx == (ADR_W-2)'(`CIRQ_IDX_CONFIG));
   wire rd_flags = hit & ~we_i & is_flags;
   wire wr_lane0 = hit & we_i & sel_i[0];
   wire [7:0] rd_byte = is_flags ? flags_reg
                      : is_enable ? enable_reg
                      : is_config ? {2'h0, cfg_reg} : 8'h00;

   // ----------------------------------------
   // Flag set and clear terms
   // ----------------------------------------
   // Power-down stops UART-side sources, card event stays live
   wire live = ~power_down_i;
   wire [7:0] set_v;
   wire [7:0] clr_v;
   assign set_v[`CIRQ_B_WAIT] = live & (cfg_reg.sync_mode ? evt.length_done
                                                           : evt.timeout);
   // Runs on the free bus clock, never the gated card clock
   assign set_v[`CIRQ_B_CARD] = det_edge | evt.fault;
   assign set_v[`CIRQ_B_SUPPLY] = live & evt.supply_timeout;
   assign set_v[`CIRQ_B_RXAV] = live & (cfg_reg.bypass ? io_fall
                                                       : evt.rx_nonempty);
   assign set_v[`CIRQ_B_TXEV] = live & ((evt.tx_empty & ~tx_empty_reg)
                                      | (evt.tx_full & ~tx_full_reg));
   // Break at byte end in T=0 with break detection enabled swallows the sent event
   assign set_v[`CIRQ_B_TX_SENT_FLAG] = live & evt.tx_sent
      & ~(cfg_reg.t0_protocol & cfg_reg.break_detect_en & evt.tx_break);
   assign set_v[`CIRQ_B_TX_ERROR_FLAG] = live & (evt.tx_break | evt.tx_underrun);
   assign set_v[`CIRQ_B_RX_ERROR_FLAG] = live & (evt.rx_overrun | evt.rx_parity);

   // Receive flag is read-cleared only in bypass, else it tracks the FIFO
   wire [7:0] cor_mask = `CIRQ_COR_MASK | (cfg_reg.bypass ? 8'h10 : 8'h00);
   assign clr_v = (rd_flags ? cor_mask : 8'h00)
                | (tx_ctl_read_i ? `CIRQ_TXRD_MASK : 8'h00)
                | (rx_ctl_read_i ? `CIRQ_RXRD_MASK : 8'h00);

   // Set wins over clear; level-following bit outside bypass
   always_comb begin
      flags_next = (flags_reg & ~clr_v) | set_v;
      if (!cfg_reg.bypass) begin
         flags_next[`CIRQ_B_RXAV] = set_v[`CIRQ_B_RXAV];
      end
   end

   // ----------------------------------------
   // Flag register and transmit level history
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_reg <= `CIRQ_FLAGS_RST;
         tx_empty_reg <= 1'b0;
         tx_full_reg <= 1'b0;
      end else begin
         flags_reg <= flags_next;
         tx_empty_reg <= evt.tx_empty;
         tx_full_reg <= evt.tx_full;
      end
   end

   // ----------------------------------------
   // Software registers and bus answer
   // ----------------------------------------
   // Access acts on the request edge, answer one cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_reg <= `CIRQ_ENABLE_RST;
         cfg_reg <= `CIRQ_CONFIG_RST;
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else begin
         ack_reg <= hit;
         if (hit) begin
            dat_reg <= we_i ? '0 : {{(DATA_W-8){1'b0}}, rd_byte};
         end
         if (wr_lane0 && is_enable) begin
            enable_reg <= dat_i[7:0];
         end
         if (wr_lane0 && is_config) begin
            cfg_reg <= dat_i[5:0];
         end
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;
   // Level from registered flags and enables only
   assign irq_o = |(flags_reg & enable_reg);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_flag_read;
      rd_flags && set_v == 8'h00 && !tx_ctl_read_i && !rx_ctl_read_i;
   endsequence

   sequence s_supply_masked;
      live && evt.supply_timeout && !enable_reg[`CIRQ_B_SUPPLY];
   endsequence

   sequence s_tx_empty_rise;
      live && evt.tx_empty && !$past(evt.tx_empty);
   endsequence

   sequence s_sent_clean;
      live && evt.tx_sent && !evt.tx_break;
   endsequence

   sequence s_rx_fault;
      live && (evt.rx_overrun || evt.rx_parity);
   endsequence

   a_irq_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      enable_reg == 8'h00 |-> !irq_o)
      else $error("interrupt without an enabled flag");

   a_irq_level_held: assert property (@(posedge clk_i) disable iff (rst_i)
      (|(flags_reg & enable_reg)) |-> irq_o)
      else $error("enabled flag set but interrupt low");

   a_read_clears_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      s_flag_read |=> (flags_reg & 8'hE4) == 8'h00)
      else $error("clear-on-read flag survived a read");

   a_masked_still_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      s_supply_masked |=> flags_reg[`CIRQ_B_SUPPLY])
      else $error("masked supply event did not set its flag");

   a_sync_length: assert property (@(posedge clk_i) disable iff (rst_i)
      live && cfg_reg.sync_mode && evt.length_done |=> flags_reg[`CIRQ_B_WAIT])
      else $error("length count did not set bit 7");

   a_rx_follows_fifo: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_reg.bypass && live |=> flags_reg[`CIRQ_B_RXAV] == $past(evt.rx_nonempty))
      else $error("receive flag does not follow the FIFO");

   a_tx_event_held: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_reg[`CIRQ_B_TXEV] && !tx_ctl_read_i |=> flags_reg[`CIRQ_B_TXEV])
      else $error("transmit event flag dropped without control read");

   a_break_blocks_sent: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_reg.t0_protocol && cfg_reg.break_detect_en && evt.tx_break && evt.tx_sent
      && !flags_reg[`CIRQ_B_TX_SENT_FLAG] |=> !flags_reg[`CIRQ_B_TX_SENT_FLAG])
      else $error("sent flag set despite break");

   a_rx_error_held: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_reg[`CIRQ_B_RX_ERROR_FLAG] && !rx_ctl_read_i |=> flags_reg[`CIRQ_B_RX_ERROR_FLAG])
      else $error("receive error flag dropped without control read");

   a_enable_reset: assert property (@(posedge clk_i)
      rst_i |=> enable_reg == 8'h00 && !irq_o)
      else $error("enable register not cleared by reset");

   a_unselected_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_field == `CIRQ_SEL_NONE && !cfg_reg.bypass |=> !flags_reg[`CIRQ_B_RXAV])
      else $error("receive flag set with no interface selected");

   a_async_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
      live && !cfg_reg.sync_mode && evt.timeout |=> flags_reg[`CIRQ_B_WAIT])
      else $error("timeout did not set bit 7");

   a_wait_held: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_reg[`CIRQ_B_WAIT] && !rd_flags |=> flags_reg[`CIRQ_B_WAIT])
      else $error("bit 7 dropped without a flag read");

   a_sync_redefines: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_reg.sync_mode && !evt.length_done && !flags_reg[`CIRQ_B_WAIT] |=> !flags_reg[`CIRQ_B_WAIT])
      else $error("bit 7 set in sync mode without length count");

   a_card_event_live: assert property (@(posedge clk_i) disable iff (rst_i)
      det_edge || evt.fault |=> flags_reg[`CIRQ_B_CARD])
      else $error("card event did not set bit 6");

   a_card_held: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_reg[`CIRQ_B_CARD] && !rd_flags |=> flags_reg[`CIRQ_B_CARD])
      else $error("bit 6 dropped without a flag read");

   a_supply_held: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_reg[`CIRQ_B_SUPPLY] && !rd_flags |=> flags_reg[`CIRQ_B_SUPPLY])
      else $error("bit 5 dropped without a flag read");

   a_bypass_io_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      live && cfg_reg.bypass && io_fall |=> flags_reg[`CIRQ_B_RXAV])
      else $error("I/O falling edge did not set bit 4 in bypass");

   a_tx_level_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      s_tx_empty_rise |=> flags_reg[`CIRQ_B_TXEV])
      else $error("transmit empty rise did not set bit 3");

   a_sent_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      s_sent_clean |=> flags_reg[`CIRQ_B_TX_SENT_FLAG])
      else $error("byte sent did not set bit 2");

   a_tx_error_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      live && (evt.tx_break || evt.tx_underrun) |=> flags_reg[`CIRQ_B_TX_ERROR_FLAG])
      else $error("transmit error did not set bit 1");

   a_tx_error_held: assert property (@(posedge clk_i) disable iff (rst_i)
      flags_reg[`CIRQ_B_TX_ERROR_FLAG] && !tx_ctl_read_i |=> flags_reg[`CIRQ_B_TX_ERROR_FLAG])
      else $error("transmit error flag dropped without control read");

   a_rx_error_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rx_fault |=> flags_reg[`CIRQ_B_RX_ERROR_FLAG])
      else $error("receive error did not set bit 0");
endmodule // smart_card_interrupt_flags
`default_nettype wire

/* verif/card_event_source.sv */
// Event source model standing in for the card UART and interface logic
`timescale 1ns/1ps
`default_nettype none
module card_event_source (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire card_irq_pkg::evt_s ext_cmd_i,
   input wire card_irq_pkg::evt_s int_cmd_i,
   output var card_irq_pkg::evt_s ext_evt_o,
   output var card_irq_pkg::evt_s int_evt_o
);
   // Registered status, as the UART gives it; recovery is left to firmware
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_evt_o <= '0;
         int_evt_o <= '0;
      end else begin
         ext_evt_o <= ext_cmd_i;
         int_evt_o <= int_cmd_i;
      end
   end
endmodule // card_event_source
`default_nettype wire

/* verif/smart_card_interrupt_flags_tb.sv */
// Self-checking bench of the card interrupt flag block
`timescale 1ns/1ps
`default_nettype none
`include "card_irq_defines.svh"
module smart_card_interrupt_flags_tb;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [17:0] adr_i = 18'h0;
   logic [31:0] dat_i = 32'h0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_o;
   logic ack_o, irq_o;
   logic cd_ext = 1'b0, io_ext = 1'b1, pwr_dn = 1'b0, tx_rd = 1'b0, rx_rd = 1'b0;
   logic cd_int = 1'b0, io_int = 1'b1;
   card_irq_pkg::evt_s ext_cmd = '0, int_cmd = '0, ext_evt, int_evt;
   logic [11:0] lvl = 12'h000;
   int errors = 0, n_tests = 0, cycles = 0;

   smart_card_interrupt_flags dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
      .ext_evt_i(ext_evt), .int_evt_i(int_evt), .card_detect_ext_i(cd_ext),
      .card_detect_int_i(cd_int), .io_ext_i(io_ext), .io_int_i(io_int), .power_down_i(pwr_dn),
      .tx_ctl_read_i(tx_rd), .rx_ctl_read_i(rx_rd), .irq_o(irq_o));
   card_event_source src (.clk_i(clk_i), .rst_i(rst_i), .ext_cmd_i(ext_cmd), .int_cmd_i(int_cmd),
      .ext_evt_o(ext_evt), .int_evt_o(int_evt));

   // Clock and hang guard; ceiling well above the two hundred or so cycles used
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         end_sim();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Classic single cycle; waits for ack without assuming latency
   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, wd};
      sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] x;
      wb(1'b1, idx, d, x);
   endtask
   task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
      logic [7:0] x;
      wb(1'b0, idx, 8'h00, x);
      chk(x, exp);
   endtask
   // One-cycle event pulse, on top of the held levels on the external interface only, then settle
   task automatic pulse(input logic on_int, input logic [11:0] p);
      @(posedge clk_i);
      if (on_int) int_cmd <= card_irq_pkg::evt_s'(p);
      else ext_cmd <= card_irq_pkg::evt_s'(p | lvl);
      @(posedge clk_i);
      ext_cmd <= card_irq_pkg::evt_s'(lvl);
      int_cmd <= '0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic strobe(input logic is_rx);
      @(posedge clk_i);
      if (is_rx) rx_rd <= 1'b1;
      else tx_rd <= 1'b1;
      @(posedge clk_i);
      rx_rd <= 1'b0;
      tx_rd <= 1'b0;
      @(posedge clk_i);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      rdc(`CIRQ_IDX_ENABLE, 8'h00);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      rdc(16'hFE03, 8'h00);
      chk({7'h0, irq_o}, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_mask();
      wr(`CIRQ_IDX_CONFIG, 8'h04);
      pulse(1'b0, 12'h200);
      chk({7'h0, irq_o}, 8'h00);
      rdc(`CIRQ_IDX_FLAGS, 8'h20);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      wr(`CIRQ_IDX_ENABLE, 8'h20);
      pulse(1'b0, 12'h200);
      chk({7'h0, irq_o}, 8'h01);
      wr(`CIRQ_IDX_ENABLE, 8'h10);
      chk({7'h0, irq_o}, 8'h00);
      wr(`CIRQ_IDX_ENABLE, 8'h20);
      rdc(`CIRQ_IDX_FLAGS, 8'h20);
      chk({7'h0, irq_o}, 8'h00);
      $display("test mask done");
   endtask
   task automatic t_select();
      pulse(1'b1, 12'h800);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      wr(`CIRQ_IDX_CONFIG, 8'h08);
      pulse(1'b1, 12'h800);
      rdc(`CIRQ_IDX_FLAGS, 8'h80);
      wr(`CIRQ_IDX_CONFIG, 8'h0C);
      pulse(1'b1, 12'h100);
      rdc(`CIRQ_IDX_FLAGS, 8'h40);
      wr(`CIRQ_IDX_CONFIG, 8'h00);
      pulse(1'b0, 12'h800);
      pulse(1'b1, 12'h800);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      $display("test select done");
   endtask
   task automatic t_txrx();
      wr(`CIRQ_IDX_CONFIG, 8'h04);
      lvl = 12'h040;
      pulse(1'b0, 12'h00F);
      rdc(`CIRQ_IDX_FLAGS, 8'h0B);
      rdc(`CIRQ_IDX_FLAGS, 8'h0B);
      strobe(1'b0);
      rdc(`CIRQ_IDX_FLAGS, 8'h01);
      strobe(1'b1);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      lvl = 12'h080;
      pulse(1'b0, 12'h000);
      rdc(`CIRQ_IDX_FLAGS, 8'h10);
      rdc(`CIRQ_IDX_FLAGS, 8'h10);
      lvl = 12'h000;
      pulse(1'b0, 12'h000);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      $display("test txrx done");
   endtask
   task automatic t_modes();
      wr(`CIRQ_IDX_CONFIG, 8'h05);
      pulse(1'b0, 12'h400);
      rdc(`CIRQ_IDX_FLAGS, 8'h80);
      wr(`CIRQ_IDX_CONFIG, 8'h34);
      pulse(1'b0, 12'h018);
      rdc(`CIRQ_IDX_FLAGS, 8'h02);
      strobe(1'b0);
      pulse(1'b0, 12'h010);
      rdc(`CIRQ_IDX_FLAGS, 8'h04);
      $display("test modes done");
   endtask
   task automatic t_pins();
      wr(`CIRQ_IDX_CONFIG, 8'h04);
      pwr_dn <= 1'b1;
      pulse(1'b0, 12'h200);
      cd_ext <= 1'b1;
      repeat (6) @(posedge clk_i);
      rdc(`CIRQ_IDX_FLAGS, 8'h40);
      cd_int <= 1'b1;
      repeat (6) @(posedge clk_i);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      pwr_dn <= 1'b0;
      wr(`CIRQ_IDX_CONFIG, 8'h06);
      wr(`CIRQ_IDX_ENABLE, 8'h00);
      io_int <= 1'b0;
      repeat (6) @(posedge clk_i);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      io_ext <= 1'b0;
      repeat (6) @(posedge clk_i);
      rdc(`CIRQ_IDX_FLAGS, 8'h10);
      rdc(`CIRQ_IDX_FLAGS, 8'h00);
      io_ext <= 1'b1;
      io_int <= 1'b1;
      $display("test pins done");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_mask();
      t_select();
      t_txrx();
      t_modes();
      t_pins();
      end_sim();
   end
endmodule // smart_card_interrupt_flags_tb
`default_nettype wire
